/* File: pc_stack_defs.svh */
// Behaviour
// - The next fetch address lives in a 13-bit program counter.
// - Counter low byte is a software register, readable and writable.
// - Counter high bits are hidden; a low byte write loads them from the high latch, while returns and interrupts load them from the stack or vector.
// - Return stack holds 8 entries of 13 bits; its pointer is hidden.
// - A call or an interrupt branch pushes onto the stack.
// - Plain return, return with literal and interrupt return pop the stack.
// - Pushes and pops never change the high latch.
// - Stack wraps circularly; the ninth push overwrites the first, silently.
// - Call and jump carry an 11-bit target within one 2K page.
// - Call and jump take the two page bits from latch bits 4:3.
// - The full 13-bit counter is pushed, so returns need no page fix.
// - Interrupt wake-up with global enable set loads the interrupt vector.
`ifndef PC_STACK_DEFS_SVH
`define PC_STACK_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// Widths
`define PC_W 13
`define TGT_W 11
`define LATCH_W 5
`define LOW_W 8
`define PAGE_BIT 3
`define APB_AW 12
`define APB_DW 32

////////////////////////////////////////////////////////////////////////////////
// Register map and reset values
`define OFF_LOW_BYTE 12'h000
`define OFF_HIGH_LATCH 12'h004
`define RESET_PC 13'h0000
`define IRQ_VECTOR 13'h0004
`define LATCH_RESET 5'h00
`define PC_STEP 13'h0001
`define PTR_STEP 1

`endif

/* File: pc_stack_pkg.sv */
`include "pc_stack_defs.svh"

package pc_stack_pkg;
	typedef logic [`PC_W-1:0] pc_t;
	typedef logic [`LATCH_W-1:0] latch_t;
	typedef enum logic [3:0] {
		op_step = 4'h0,
		op_call = 4'h1,
		op_jump = 4'h2,
		op_return = 4'h3,
		op_ret_lit = 4'h4,
		op_ret_irq = 4'h5,
		op_irq_branch = 4'h6,
		op_wake = 4'h7,
		op_write_low = 4'h8,
		op_hold = 4'h9
	} op_t;
endpackage : pc_stack_pkg

/* File: stack_mem_if.sv */
`timescale 1ns/100ps

interface stack_mem_if #(parameter int DEPTH = 8, parameter int PTR_W = 3);
	logic wr_en;
	logic [PTR_W-1:0] wr_addr;
	pc_stack_pkg::pc_t wr_data;
	logic [PTR_W-1:0] rd_addr;
	pc_stack_pkg::pc_t rd_data;
	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : stack_mem_if

/* File: stack_ram.sv */
`timescale 1ns/100ps
`include "pc_stack_defs.svh"

module stack_ram #(
	parameter int DEPTH = 8,
	parameter int PTR_W = 3
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// Stack port
	stack_mem_if.mem port
);
	pc_stack_pkg::pc_t mem_q [DEPTH];
	pc_stack_pkg::pc_t rd_q;

	assign port.rd_data = rd_q;

	// Entries sit outside program and data space
	always_ff @(posedge pclk) begin
		if (clk_en && port.wr_en) begin
			mem_q[port.wr_addr] <= port.wr_data;
		end
	end

	// Registered read with write bypass, so a fresh push is the new top
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_q <= `RESET_PC;
		end else if (clk_en) begin
			if (port.wr_en && port.wr_addr == port.rd_addr) begin
				rd_q <= port.wr_data;
			end else begin
				rd_q <= mem_q[port.rd_addr];
			end
		end
	end
endmodule : stack_ram

/* File: program_counter_stack.sv */
`timescale 1ns/100ps
`include "pc_stack_defs.svh"

module program_counter_stack #(
	parameter int DEPTH = 8,
	parameter int PTR_W = 3
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`APB_AW-1:0] paddr,
	input wire logic [`APB_DW-1:0] pwdata,
	output logic [`APB_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Instruction decoder
	input wire logic op_valid,
	input wire pc_stack_pkg::op_t op_code,
	input wire logic [`TGT_W-1:0] target_addr,
	input wire logic [`LOW_W-1:0] low_byte_data,
	input wire logic global_irq_enable,
	output logic op_ready,
	// Program memory fetch
	output logic [`PC_W-1:0] fetch_addr
);

	////////////////////////////////////////////////////////////////////////////
	// State
	pc_stack_pkg::pc_t pc_q;
	pc_stack_pkg::pc_t pc_d;
	pc_stack_pkg::latch_t latch_q;
	logic [PTR_W-1:0] ptr_q;
	logic [PTR_W-1:0] ptr_d;
	logic [`APB_DW-1:0] prdata_q;
	logic push;
	logic pop;
	pc_stack_pkg::pc_t push_data;
	pc_stack_pkg::pc_t jump_target;
	pc_stack_pkg::pc_t step_pc;
	logic op_take;

	stack_mem_if #(.DEPTH(DEPTH), .PTR_W(PTR_W)) stk ();

	stack_ram #(.DEPTH(DEPTH), .PTR_W(PTR_W)) u_stack (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.port(stk.mem)
	);

	////////////////////////////////////////////////////////////////////////////
	// APB decode
	logic apb_setup;
	logic apb_access;
	logic hit_low;
	logic hit_latch;
	logic low_wr;
	logic latch_wr;

	assign apb_setup = psel && !penable;
	assign apb_access = psel && penable;

	always_comb begin
		hit_low = 1'b0;
		hit_latch = 1'b0;
		if (paddr == `OFF_LOW_BYTE) begin
			hit_low = 1'b1;
		end else if (paddr == `OFF_HIGH_LATCH) begin
			hit_latch = 1'b1;
		end
	end

	// Frozen block cannot take a transfer
	assign pready = clk_en;
	assign pslverr = apb_access && !(hit_low || hit_latch);
	assign prdata = prdata_q;
	assign low_wr = apb_access && pwrite && hit_low && clk_en;
	assign latch_wr = apb_access && pwrite && hit_latch && clk_en;

	// Read data captured in setup, stable through the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
		end else if (clk_en && apb_setup) begin
			if (pwrite) begin
				prdata_q <= '0;
			end else if (hit_low) begin
				prdata_q <= {{(`APB_DW-`LOW_W){1'b0}}, pc_q[`LOW_W-1:0]};
			end else if (hit_latch) begin
				prdata_q <= {{(`APB_DW-`LATCH_W){1'b0}}, latch_q};
			end else begin
				prdata_q <= '0;
			end
		end
	end

	// High latch: software only, untouched by stack traffic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_q <= `LATCH_RESET;
		end else if (latch_wr) begin
			latch_q <= pwdata[`LATCH_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencing
	// A software write of the low byte owns the counter for that cycle
	assign op_ready = !(apb_access && pwrite && hit_low);
	assign op_take = op_valid && op_ready && clk_en;
	assign step_pc = pc_q + `PC_STEP;
	assign jump_target = {latch_q[`LATCH_W-1:`PAGE_BIT], target_addr};

	always_comb begin
		pc_d = pc_q;
		push = 1'b0;
		pop = 1'b0;
		push_data = step_pc;
		if (low_wr) begin
			pc_d = {latch_q, pwdata[`LOW_W-1:0]};
		end else if (op_take) begin
			case (op_code)
				pc_stack_pkg::op_step: begin
					pc_d = step_pc;
				end
				pc_stack_pkg::op_call: begin
					push = 1'b1;
					push_data = step_pc;
					pc_d = jump_target;
				end
				pc_stack_pkg::op_jump: begin
					pc_d = jump_target;
				end
				pc_stack_pkg::op_return, pc_stack_pkg::op_ret_lit, pc_stack_pkg::op_ret_irq: begin
					pop = 1'b1;
					pc_d = stk.rd_data;
				end
				pc_stack_pkg::op_irq_branch: begin
					push = 1'b1;
					push_data = pc_q;
					pc_d = `IRQ_VECTOR;
				end
				pc_stack_pkg::op_wake: begin
					if (global_irq_enable) begin
						push = 1'b1;
						push_data = pc_q;
						pc_d = `IRQ_VECTOR;
					end else begin
						pc_d = step_pc;
					end
				end
				pc_stack_pkg::op_write_low: begin
					pc_d = {latch_q, low_byte_data};
				end
				default: begin
					pc_d = pc_q;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_q <= `RESET_PC;
		end else if (clk_en) begin
			pc_q <= pc_d;
		end
	end

	assign fetch_addr = pc_q;

	////////////////////////////////////////////////////////////////////////////
	// Return stack pointer, wraps with no overflow flag
	always_comb begin
		ptr_d = ptr_q;
		if (push) begin
			ptr_d = ptr_q + PTR_W'(`PTR_STEP);
		end else if (pop) begin
			ptr_d = ptr_q - PTR_W'(`PTR_STEP);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_q <= '0;
		end else if (clk_en) begin
			ptr_q <= ptr_d;
		end
	end

	assign stk.wr_en = push;
	assign stk.wr_addr = ptr_q;
	assign stk.wr_data = push_data;
	// Prefetch the entry that will be on top after this cycle
	assign stk.rd_addr = ptr_d - PTR_W'(`PTR_STEP);

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence call_s;
		op_take && !low_wr && op_code == pc_stack_pkg::op_call;
	endsequence

	sequence ret_s;
		op_take && !low_wr && (op_code == pc_stack_pkg::op_return || op_code == pc_stack_pkg::op_ret_lit
			|| op_code == pc_stack_pkg::op_ret_irq);
	endsequence

	sequence step_s;
		op_take && !low_wr && op_code == pc_stack_pkg::op_step;
	endsequence

	property frozen_p;
		!clk_en |=> $stable(pc_q) && $stable(ptr_q);
	endproperty

	pc_step_a: assert property (step_s |=> pc_q == $past(pc_q) + `PC_STEP)
		else $error("counter did not advance by one");

	call_target_a: assert property (call_s |=> pc_q == {$past(latch_q[`LATCH_W-1:`PAGE_BIT]),
		$past(target_addr)})
		else $error("call target or page bit wrong");

	jump_target_a: assert property (op_take && !low_wr && op_code == pc_stack_pkg::op_jump
		|=> pc_q[`TGT_W-1:0] == $past(target_addr))
		else $error("jump target wrong");

	push_ptr_a: assert property (call_s |=> ptr_q == $past(ptr_q) + PTR_W'(`PTR_STEP))
		else $error("push did not advance stack pointer");

	call_return_a: assert property (call_s ##1 (ret_s and clk_en) |=> pc_q == $past(pc_q, 2) + `PC_STEP)
		else $error("return did not restore full address");

	pop_load_a: assert property (ret_s |=> pc_q == $past(stk.rd_data))
		else $error("return did not load top of stack");

	latch_kept_a: assert property ((push || pop) && !latch_wr |=> $stable(latch_q))
		else $error("stack traffic changed high latch");

	low_write_a: assert property (low_wr |=> pc_q == {$past(latch_q), $past(pwdata[`LOW_W-1:0])})
		else $error("low byte write did not load high bits");

	wake_vector_a: assert property (op_take && !low_wr && op_code == pc_stack_pkg::op_wake && global_irq_enable
		|=> pc_q == `IRQ_VECTOR)
		else $error("wake-up did not reach vector");

	low_read_a: assert property (apb_setup && !pwrite && hit_low && clk_en
		|=> prdata[`LOW_W-1:0] == $past(pc_q[`LOW_W-1:0]))
		else $error("low byte read wrong");

	stack_wrap_a: assert property (push && ptr_q == PTR_W'(DEPTH - 1) && clk_en |=> ptr_q == '0)
		else $error("stack pointer did not wrap");

	state_frozen_a: assert property (frozen_p)
		else $error("state moved while clock enable low");

	////////////////////////////////////////////////////////////////////////////
	// Further operation checks
	sequence irq_s;
		op_take && !low_wr && (op_code == pc_stack_pkg::op_irq_branch
			|| (op_code == pc_stack_pkg::op_wake && global_irq_enable));
	endsequence

	sequence wake_plain_s;
		op_take && !low_wr && op_code == pc_stack_pkg::op_wake && !global_irq_enable;
	endsequence

	sequence jump_s;
		op_take && !low_wr && op_code == pc_stack_pkg::op_jump;
	endsequence

	sequence hold_s;
		op_take && !low_wr && op_code == pc_stack_pkg::op_hold;
	endsequence

	sequence dec_write_s;
		op_take && !low_wr && op_code == pc_stack_pkg::op_write_low;
	endsequence

	sequence latch_rd_s;
		apb_setup && !pwrite && hit_latch && clk_en;
	endsequence

	irq_vector_a: assert property (irq_s |=> pc_q == `IRQ_VECTOR)
		else $error("interrupt branch did not reach vector");

	irq_push_a: assert property (irq_s |=> ptr_q == $past(ptr_q) + PTR_W'(`PTR_STEP))
		else $error("interrupt branch did not push");

	irq_return_a: assert property (irq_s ##1 ret_s |=> pc_q == $past(pc_q, 2))
		else $error("interrupt return did not restore address");

	pop_ptr_a: assert property (ret_s |=> ptr_q == $past(ptr_q) - PTR_W'(`PTR_STEP))
		else $error("return did not move stack pointer back");

	pop_wrap_a: assert property (pop && ptr_q == '0 |=> ptr_q == PTR_W'(DEPTH - 1))
		else $error("stack pointer did not wrap on pop");

	wake_step_a: assert property (wake_plain_s |=> pc_q == $past(pc_q) + `PC_STEP)
		else $error("plain wake-up did not step counter");

	wake_keep_a: assert property (wake_plain_s |=> $stable(ptr_q))
		else $error("plain wake-up touched the stack");

	jump_page_a: assert property (jump_s |=> pc_q[`PC_W-1:`TGT_W] == $past(latch_q[`LATCH_W-1:`PAGE_BIT]))
		else $error("jump page bits wrong");

	jump_keep_a: assert property (jump_s |=> $stable(ptr_q))
		else $error("jump touched the stack");

	hold_still_a: assert property (hold_s |=> $stable(pc_q) && $stable(ptr_q))
		else $error("hold changed state");

	dec_write_a: assert property (dec_write_s |=> pc_q == {$past(latch_q), $past(low_byte_data)})
		else $error("decoder low byte write wrong");

	latch_write_a: assert property (latch_wr |=> latch_q == $past(pwdata[`LATCH_W-1:0]))
		else $error("high latch write lost");

	pc_idle_a: assert property (clk_en && !op_take && !low_wr |=> $stable(pc_q))
		else $error("counter moved with no operation");

	ptr_idle_a: assert property (clk_en && !push && !pop |=> $stable(ptr_q))
		else $error("stack pointer moved with no stack traffic");

	read_hold_a: assert property (apb_access && clk_en |=> $stable(prdata))
		else $error("read data changed after access");

	latch_read_a: assert property (latch_rd_s
		|=> prdata == {{(`APB_DW-`LATCH_W){1'b0}}, $past(latch_q)})
		else $error("high latch read wrong");

	step_keep_a: assert property (step_s |=> $stable(ptr_q))
		else $error("step touched the stack");

	write_keep_a: assert property (low_wr |=> $stable(ptr_q))
		else $error("low byte write touched the stack");

endmodule : program_counter_stack

/* File: decoder_model.sv */
`timescale 1ns/100ps
`include "pc_stack_defs.svh"

module decoder_model (
	// Clock
	input wire logic pclk,
	// Decoder handshake
	input wire logic op_ready,
	output logic op_valid,
	output pc_stack_pkg::op_t op_code,
	output logic [`TGT_W-1:0] target_addr,
	output logic [`LOW_W-1:0] low_byte_data,
	output logic global_irq_enable
);
	initial begin
		op_valid = 1'b0;
		op_code = pc_stack_pkg::op_hold;
		target_addr = 11'h000;
		low_byte_data = 8'h00;
		global_irq_enable = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One operation, held until taken
	task issue(input pc_stack_pkg::op_t c, input logic [`TGT_W-1:0] t, input logic [`LOW_W-1:0] d, input logic g);
		op_valid <= 1'b1;
		op_code <= c;
		target_addr <= t;
		low_byte_data <= d;
		global_irq_enable <= g;
		do @(posedge pclk); while (op_ready !== 1'b1);
		op_valid <= 1'b0;
		target_addr <= ~t;
		low_byte_data <= ~d;
		@(posedge pclk);
	endtask : issue

	// Two operations on consecutive edges
	task issue_pair(input pc_stack_pkg::op_t c0, input logic [`TGT_W-1:0] t0, input pc_stack_pkg::op_t c1,
		input logic [`TGT_W-1:0] t1);
		op_valid <= 1'b1;
		op_code <= c0;
		target_addr <= t0;
		global_irq_enable <= 1'b1;
		do @(posedge pclk); while (op_ready !== 1'b1);
		op_code <= c1;
		target_addr <= t1;
		do @(posedge pclk); while (op_ready !== 1'b1);
		op_valid <= 1'b0;
		@(posedge pclk);
	endtask : issue_pair
endmodule : decoder_model

/* File: tb_program_counter_stack.sv */
`timescale 1ns/100ps
`include "pc_stack_defs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
	$display("Error %0t: got %h expected %h", $time, a, b); end end

module tb_program_counter_stack;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, op_ready, op_valid, global_irq_enable, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	pc_stack_pkg::op_t op_code;
	logic [10:0] target_addr;
	logic [7:0] low_byte_data;
	logic [12:0] fetch_addr;
	int num_errors, checked, cycles;

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	program_counter_stack DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.op_valid(op_valid), .op_code(op_code), .target_addr(target_addr), .low_byte_data(low_byte_data),
		.global_irq_enable(global_irq_enable), .op_ready(op_ready), .fetch_addr(fetch_addr));
	decoder_model dec (.pclk(pclk), .op_ready(op_ready), .op_valid(op_valid), .op_code(op_code),
		.target_addr(target_addr), .low_byte_data(low_byte_data), .global_irq_enable(global_irq_enable));

	////////////////////////////////////////////////////////////////////////////////
	// Bus and decoder helpers
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task op(input pc_stack_pkg::op_t c, input logic [10:0] t, input logic [12:0] exp);
		dec.issue(c, t, 8'h00, 1'b1);
		`CHK(fetch_addr, exp)
	endtask : op

	task stop_test;
		$display("Mismatches %0d, comparisons %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task reset_values;
		`CHK(fetch_addr, 13'h0000)
		apb(1'b0, 12'h000, 32'h0);
		`CHK(rd, 32'h00000000)
		apb(1'b0, 12'h004, 32'h0);
		`CHK(rd, 32'h00000000)
	endtask : reset_values

	task counter_wrap;
		apb(1'b1, 12'h004, 32'hffffffff);
		apb(1'b0, 12'h004, 32'h0);
		`CHK(rd, 32'h0000001f)
		apb(1'b1, 12'h000, 32'h000000fe);
		`CHK(fetch_addr, 13'h1ffe)
		apb(1'b0, 12'h000, 32'h0);
		`CHK(rd, 32'h000000fe)
		op(pc_stack_pkg::op_step, 11'h000, 13'h1fff);
		op(pc_stack_pkg::op_step, 11'h000, 13'h0000);
	endtask : counter_wrap

	task page_select;
		apb(1'b1, 12'h004, 32'h0000000a);
		op(pc_stack_pkg::op_jump, 11'h7ff, 13'h0fff);
		op(pc_stack_pkg::op_call, 11'h123, 13'h0923);
		op(pc_stack_pkg::op_return, 11'h000, 13'h1000);
		apb(1'b0, 12'h004, 32'h0);
		`CHK(rd, 32'h0000000a)
	endtask : page_select

	task stack_ring;
		apb(1'b1, 12'h004, 32'h0);
		for (int i = 0; i < 9; i++) begin
			op(pc_stack_pkg::op_jump, 11'(i * 16), 13'(i * 16));
			op(pc_stack_pkg::op_call, 11'h7f0, 13'h07f0);
		end
		for (int i = 8; i > 0; i--)
			op(pc_stack_pkg::op_return, 11'h000, 13'(i * 16 + 1));
	endtask : stack_ring

	task irq_paths;
		op(pc_stack_pkg::op_jump, 11'h055, 13'h0055);
		op(pc_stack_pkg::op_irq_branch, 11'h000, 13'h0004);
		op(pc_stack_pkg::op_ret_irq, 11'h000, 13'h0055);
		op(pc_stack_pkg::op_wake, 11'h000, 13'h0004);
		op(pc_stack_pkg::op_ret_lit, 11'h000, 13'h0055);
		dec.issue(pc_stack_pkg::op_wake, 11'h000, 8'h00, 1'b0);
		`CHK(fetch_addr, 13'h0056)
		op(pc_stack_pkg::op_hold, 11'h000, 13'h0056);
		dec.issue(pc_stack_pkg::op_write_low, 11'h000, 8'h33, 1'b0);
		`CHK(fetch_addr, 13'h0033)
	endtask : irq_paths

	task unmapped;
		apb(1'b1, 12'h008, 32'h000000ff);
		`CHK(err, 1'b1)
		apb(1'b0, 12'h008, 32'h0);
		`CHK(rd, 32'h00000000)
		`CHK(err, 1'b1)
	endtask : unmapped

	task freeze;
		clk_en <= 1'b0;
		fork
			apb(1'b1, 12'h000, 32'h000000aa);
			begin
				repeat (3) @(posedge pclk);
				`CHK(fetch_addr, 13'h0033)
				`CHK(pready, 1'b0)
				`CHK(op_ready, 1'b0)
				clk_en <= 1'b1;
			end
		join
		`CHK(fetch_addr, 13'h00aa)
	endtask : freeze

	task back_to_back;
		dec.issue_pair(pc_stack_pkg::op_call, 11'h200, pc_stack_pkg::op_return, 11'h000);
		`CHK(fetch_addr, 13'h00ab)
		dec.issue_pair(pc_stack_pkg::op_irq_branch, 11'h000, pc_stack_pkg::op_ret_irq, 11'h000);
		`CHK(fetch_addr, 13'h00ab)
	endtask : back_to_back

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence and hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			stop_test();
		end
	end

	initial begin
		presetn = 1'b0;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		reset_values();
		counter_wrap();
		page_select();
		stack_ring();
		irq_paths();
		unmapped();
		freeze();
		back_to_back();
		stop_test();
	end
endmodule : tb_program_counter_stack
